// ==== hdl/serial_host_port_dev.sv ====
// Purpose: Module end of the RS232 host link with RTS/CTS handshake.
// Assumes: One clock; link inputs are asynchronous and synchronised here.
// Notes on behaviour
// - Characters are eight data, no parity, one stop.
// - Plain serial link has only transmit and receive.
// - Plain link rates 4.8 to 2000 kbps.
// - RS232 host link rates 4.8 to 1000 kbps.
// - Sample CTS before each byte; send if high.
// - CTS low at boundary: idle line, wait.
// - CTS drop mid-byte: finish the byte first.
// - Byte finished under low CTS is not resent.
// - RTS low while busy; host withholds bytes then.
// - RTS pulses low while byte moves to FIFO.
// - Host without handshake ties CTS high.
// - Positioning port typical 115.2, max 1000 kbps; here the pos lines are only held idle high.
`timescale 1ns/1ps
`include "serial_link_params.svh"
module serial_host_port_dev
    import serial_link_pkg::*;
#(
    parameter int BAUD_BPS = `BAUD_TYP_BPS
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    serial_link_if.device link,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i
);
    localparam int BIT_CYC = `CLK_HZ / BAUD_BPS;
    localparam int HALF_CYC = BIT_CYC / 2;
    if (BAUD_BPS < `BAUD_MIN_BPS || BAUD_BPS > `BAUD_MAX_RS232_BPS) begin : g_baud_chk
        $error("BAUD_BPS outside the supported range");
    end

    // Link inputs pass two flip-flops before use.
    logic rxd_m_r, rxd_s_r, cts_m_r, cts_s_r;
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rxd_m_r <= 1'b1;
            rxd_s_r <= 1'b1;
            cts_m_r <= 1'b0;
            cts_s_r <= 1'b0;
        end else begin
            rxd_m_r <= link.host_to_dev_rxd;
            rxd_s_r <= rxd_m_r;
            cts_m_r <= link.host_cts;
            cts_s_r <= cts_m_r;
        end
    end

    // Transmitter.
    tx_state_e tx_st_r;
    logic [15:0] tx_cnt_r;
    logic [2:0] tx_bit_r;
    logic [7:0] tx_sh_r;
    logic tx_line_r;
    wire tx_tick = (tx_cnt_r == 16'(BIT_CYC - 1));
    assign tx_ready_o = (tx_st_r == TX_IDLE) && cts_s_r;
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            tx_st_r <= TX_IDLE;
            tx_cnt_r <= 16'h0000;
            tx_bit_r <= 3'h0;
            tx_sh_r <= 8'h00;
            tx_line_r <= 1'b1;
        end else begin
            tx_cnt_r <= (tx_st_r == TX_IDLE || tx_tick) ? 16'h0000 : tx_cnt_r + 16'h0001;
            case (tx_st_r)
                TX_IDLE: begin
                    tx_line_r <= 1'b1;
                    if (tx_valid_i && cts_s_r) begin
                        tx_sh_r <= tx_data_i;
                        tx_line_r <= 1'b0;
                        tx_st_r <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_tick) begin
                        tx_line_r <= tx_sh_r[0];
                        tx_sh_r <= {1'b0, tx_sh_r[7:1]};
                        tx_bit_r <= 3'h0;
                        tx_st_r <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    // CTS is not looked at here, so a byte in flight always completes.
                    if (tx_tick) begin
                        if (tx_bit_r == 3'h7) begin
                            tx_line_r <= 1'b1;
                            tx_st_r <= TX_STOP;
                        end else begin
                            tx_line_r <= tx_sh_r[0];
                            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
                            tx_bit_r <= tx_bit_r + 3'h1;
                        end
                    end
                end
                TX_STOP: begin
                    if (tx_tick) begin
                        tx_st_r <= TX_IDLE;
                    end
                end
                default: begin
                    tx_st_r <= TX_IDLE;
                    tx_line_r <= 1'b1;
                end
            endcase
        end
    end
    assign link.dev_to_host_txd = tx_line_r;
    assign link.pos_txd = 1'b1;

    // Receiver.
    rx_state_e rx_st_r;
    logic [15:0] rx_cnt_r;
    logic [2:0] rx_bit_r;
    logic [7:0] rx_sh_r;
    logic rx_done_r;
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rx_st_r <= RX_IDLE;
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= 3'h0;
            rx_sh_r <= 8'h00;
            rx_done_r <= 1'b0;
        end else begin
            rx_done_r <= 1'b0;
            case (rx_st_r)
                RX_IDLE: begin
                    rx_cnt_r <= 16'h0000;
                    if (!rxd_s_r) begin
                        rx_st_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_cnt_r == 16'(HALF_CYC - 1)) begin
                        rx_cnt_r <= 16'h0000;
                        rx_bit_r <= 3'h0;
                        rx_st_r <= rxd_s_r ? RX_IDLE : RX_DATA;
                    end else begin
                        rx_cnt_r <= rx_cnt_r + 16'h0001;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt_r == 16'(BIT_CYC - 1)) begin
                        rx_cnt_r <= 16'h0000;
                        rx_sh_r <= {rxd_s_r, rx_sh_r[7:1]};
                        rx_bit_r <= rx_bit_r + 3'h1;
                        if (rx_bit_r == 3'h7) begin
                            rx_st_r <= RX_STOP;
                        end
                    end else begin
                        rx_cnt_r <= rx_cnt_r + 16'h0001;
                    end
                end
                RX_STOP: begin
                    if (rx_cnt_r == 16'(BIT_CYC - 1)) begin
                        rx_cnt_r <= 16'h0000;
                        rx_done_r <= rxd_s_r; // A missing stop bit drops the byte.
                        rx_st_r <= RX_IDLE;
                    end else begin
                        rx_cnt_r <= rx_cnt_r + 16'h0001;
                    end
                end
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // Two-entry receive buffer; a byte that arrives while both entries are full is dropped.
    logic [7:0] buf_r [2];
    logic [1:0] cnt_r;
    logic wptr_r, rptr_r;
    logic [2:0] mv_cnt_r;
    wire buf_full = (cnt_r == 2'h2);
    wire push = rx_done_r && !buf_full;
    wire pop = rx_valid_o && rx_ready_i;
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            cnt_r <= 2'h0;
            wptr_r <= 1'b0;
            rptr_r <= 1'b0;
        end else begin
            if (push) begin
                buf_r[wptr_r] <= rx_sh_r;
                wptr_r <= ~wptr_r;
            end
            if (pop) begin
                rptr_r <= ~rptr_r;
            end
            cnt_r <= cnt_r + 2'(push) - 2'(pop);
        end
    end
    assign rx_valid_o = (cnt_r != 2'h0);
    assign rx_data_o = buf_r[rptr_r];

    // RTS low for a short pulse per byte moved, and while the buffer is full.
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            mv_cnt_r <= 3'h0;
        end else if (rx_done_r) begin
            mv_cnt_r <= 3'(`RTS_PULSE_CYC);
        end else if (mv_cnt_r != 3'h0) begin
            mv_cnt_r <= mv_cnt_r - 3'h1;
        end
    end
    logic rts_r;
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rts_r <= 1'b0;
        end else begin
            rts_r <= (mv_cnt_r == 3'h0) && !rx_done_r && !buf_full;
        end
    end
    assign link.dev_rts = rts_r;
endmodule

// ==== hdl/serial_host_port_host.sv ====
// Purpose: Host end of the RS232 link with RTS/CTS handshake.
// Assumes: One clock; device lines are synchronised here.
// Notes: With use_flow_i low, CTS is held high and RTS ignored.
`timescale 1ns/1ps
`include "serial_link_params.svh"
module serial_host_port_host
    import serial_link_pkg::*;
#(
    parameter int BAUD_BPS = `BAUD_TYP_BPS
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    serial_link_if.host link,
    input wire logic use_flow_i,
    input wire logic cts_allow_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o
);
    localparam int BIT_CYC = `CLK_HZ / BAUD_BPS;
    localparam int HALF_CYC = BIT_CYC / 2;
    if (BAUD_BPS < `BAUD_MIN_BPS || BAUD_BPS > `BAUD_MAX_RS232_BPS) begin : g_baud_chk
        $error("BAUD_BPS outside the supported range");
    end
    // Plain mode shares this frame logic, so its own ceiling is refused as well.
    if (BAUD_BPS > `BAUD_MAX_UART_BPS) begin : g_plain_baud_chk
        $error("BAUD_BPS above the plain link ceiling");
    end
    logic d_m_r, d_s_r, rts_m_r, rts_s_r;
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            d_m_r <= 1'b1;
            d_s_r <= 1'b1;
            rts_m_r <= 1'b0;
            rts_s_r <= 1'b0;
        end else begin
            d_m_r <= link.dev_to_host_txd;
            d_s_r <= d_m_r;
            rts_m_r <= link.dev_rts;
            rts_s_r <= rts_m_r;
        end
    end
    assign link.host_cts = use_flow_i ? cts_allow_i : 1'b1;
    assign link.pos_rxd = 1'b1;

    // Transmit: 10-bit frame shifted LSB first.
    logic [9:0] sh_r;
    logic [3:0] nb_r;
    logic [15:0] tc_r;
    wire go_ok = !use_flow_i || rts_s_r;
    assign tx_ready_o = (nb_r == 4'h0) && go_ok;
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            sh_r <= 10'h3FF;
            nb_r <= 4'h0;
            tc_r <= 16'h0000;
        end else if (nb_r == 4'h0) begin
            if (tx_valid_i && go_ok) begin
                sh_r <= {1'b1, tx_data_i, 1'b0};
                nb_r <= 4'hA;
                tc_r <= 16'h0000;
            end
        end else if (tc_r == 16'(BIT_CYC - 1)) begin
            tc_r <= 16'h0000;
            sh_r <= {1'b1, sh_r[9:1]};
            nb_r <= nb_r - 4'h1;
        end else begin
            tc_r <= tc_r + 16'h0001;
        end
    end
    assign link.host_to_dev_rxd = sh_r[0];

    // Receive: mid-bit sampling, 8N1.
    logic busy_r;
    logic [3:0] rb_r;
    logic [15:0] rc_r;
    logic [8:0] rs_r;
    logic [7:0] rd_r;
    logic rv_r;
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            busy_r <= 1'b0;
            rb_r <= 4'h0;
            rc_r <= 16'h0000;
            rs_r <= 9'h000;
            rd_r <= 8'h00;
            rv_r <= 1'b0;
        end else begin
            rv_r <= 1'b0;
            if (!busy_r) begin
                if (!d_s_r) begin
                    busy_r <= 1'b1;
                    rb_r <= 4'h0;
                    rc_r <= 16'(HALF_CYC);
                end
            end else if (rc_r == 16'(BIT_CYC - 1)) begin
                rc_r <= 16'h0000;
                rs_r <= {d_s_r, rs_r[8:1]};
                rb_r <= rb_r + 4'h1;
                // The ninth sample after the start bit is the stop bit; the byte is complete.
                if (rb_r == 4'h9) begin
                    busy_r <= 1'b0;
                    rd_r <= rs_r[8:1];
                    rv_r <= d_s_r;
                end
            end else begin
                rc_r <= rc_r + 16'h0001;
            end
        end
    end
    assign rx_data_o = rd_r;
    assign rx_valid_o = rv_r;
endmodule

// ==== hdl/serial_link_if.sv ====
// Purpose: Wires between the module end and the host end.
// Assumes: Both ends share clk_sys_i.
// Notes: Lines idle high; handshake lines are active high for go.
`timescale 1ns/1ps
interface serial_link_if;
    logic dev_to_host_txd;
    logic host_to_dev_rxd;
    logic dev_rts;
    logic host_cts;
    logic pos_txd;
    logic pos_rxd;
    modport device (
        output dev_to_host_txd,
        input host_to_dev_rxd,
        output dev_rts,
        input host_cts,
        output pos_txd,
        input pos_rxd
    );
    modport host (
        input dev_to_host_txd,
        output host_to_dev_rxd,
        input dev_rts,
        output host_cts,
        input pos_txd,
        output pos_rxd
    );
endinterface

// ==== hdl/serial_link_params.svh ====
// Purpose: Timing and framing constants for the serial host port.
// Assumes: System clock of 25 MHz.
// Notes: Bit rates are in bits per second.
`ifndef SERIAL_LINK_PARAMS_SVH
`define SERIAL_LINK_PARAMS_SVH
`define CLK_HZ 25000000
`define BAUD_MIN_BPS 4800
`define BAUD_TYP_BPS 115200
`define BAUD_MAX_UART_BPS 2000000
`define BAUD_MAX_RS232_BPS 1000000
`define DATA_BITS 8
`define STOP_BITS 1
`define RTS_PULSE_CYC 2
`endif

// ==== hdl/serial_link_pkg.sv ====
// Purpose: Types shared by both ends of the serial host port.
// Assumes: Nothing beyond the constants header.
// Notes: States use Gray codes along the usual path.
package serial_link_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b11,
        TX_STOP = 2'b10
    } tx_state_e;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } rx_state_e;
endpackage

// ==== verif/serial_host_port_checker.sv ====
// Purpose: Wire checks between the two ends of the serial host port.
// Assumes: One clock; both data lines idle high.
// Notes: A frame counter follows each line from its start bit.
`timescale 1ns/1ps
module serial_host_port_checker #(
    parameter int BIT_CYC = 25
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic dev_to_host_txd,
    input wire logic host_to_dev_rxd,
    input wire logic dev_rts,
    input wire logic host_cts,
    input wire logic pos_txd,
    input wire logic pos_rxd
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);
    int dev_fr_r;
    int host_fr_r;
    logic dev_sof;
    logic host_sof;
    assign dev_sof = (dev_fr_r == 0) && !dev_to_host_txd;
    assign host_sof = (host_fr_r == 0) && !host_to_dev_rxd;
    // Wrap one cycle early so that a start bit right after a stop bit is still caught.
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || dev_fr_r == 10 * BIT_CYC - 1) begin
            dev_fr_r <= 0;
        end else if (dev_sof || dev_fr_r != 0) begin
            dev_fr_r <= dev_fr_r + 1;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || host_fr_r == 10 * BIT_CYC - 1) begin
            host_fr_r <= 0;
        end else if (host_sof || host_fr_r != 0) begin
            host_fr_r <= host_fr_r + 1;
        end
    end
    property p_dev_start;
        (dev_fr_r > 0 && dev_fr_r < BIT_CYC) |-> !dev_to_host_txd;
    endproperty
    a_dev_start: assert property (p_dev_start) else $error("device start bit too short");
    property p_dev_stop;
        (dev_fr_r >= 9 * BIT_CYC) |-> dev_to_host_txd;
    endproperty
    a_dev_stop: assert property (p_dev_stop) else $error("device stop bit missing");
    property p_host_start;
        (host_fr_r > 0 && host_fr_r < BIT_CYC) |-> !host_to_dev_rxd;
    endproperty
    a_host_start: assert property (p_host_start) else $error("host start bit too short");
    property p_host_stop;
        (host_fr_r >= 9 * BIT_CYC) |-> host_to_dev_rxd;
    endproperty
    a_host_stop: assert property (p_host_stop) else $error("host stop bit missing");
    // Allow for the two-flop synchroniser in front of the device's transmit gate.
    property p_cts_gate;
        dev_sof |-> ($past(host_cts, 2) || $past(host_cts, 3) || $past(host_cts, 4));
    endproperty
    a_cts_gate: assert property (p_cts_gate) else $error("byte started with CTS low");
    property p_rts_pulse;
        $fell(dev_rts) |-> !dev_rts [*3];
    endproperty
    a_rts_pulse: assert property (p_rts_pulse) else $error("RTS pulse too short");
    property p_rts_in_stop;
        $fell(dev_rts) |-> host_to_dev_rxd;
    endproperty
    a_rts_in_stop: assert property (p_rts_in_stop) else $error("RTS fell mid character");
    property p_pos_idle;
        pos_txd && pos_rxd;
    endproperty
    a_pos_idle: assert property (p_pos_idle) else $error("positioning line not idle");
    c_dev_frame: cover property (dev_sof);
    c_host_frame: cover property (host_sof);
    c_rts_pulse: cover property ($fell(dev_rts));
    c_cts_drop: cover property (dev_fr_r != 0 && !host_cts);
endmodule

// ==== verif/test_serial_host_port_flow_control.sv ====
// Purpose: Bench for both ends of the serial host port joined by their link.
// Assumes: 25 MHz clock and 1 Mbit/s on both ends, so a bit lasts 25 cycles.
// Notes: Received bytes are queued at each end and compared in order.
`timescale 1ns/1ps
`include "serial_link_params.svh"
module test_serial_host_port_flow_control;
    import serial_link_pkg::*;
    localparam int BIT = 25;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic use_flow = 1'b1;
    logic cts_allow = 1'b1;
    byte_t d_tx_data = 8'h00;
    logic d_tx_valid = 1'b0;
    logic d_tx_ready;
    byte_t d_rx_data;
    logic d_rx_valid;
    logic d_rx_ready = 1'b1;
    byte_t h_tx_data = 8'h00;
    logic h_tx_valid = 1'b0;
    logic h_tx_ready;
    byte_t h_rx_data;
    logic h_rx_valid;
    int err_count = 0;
    int n_tests = 0;
    int rts_lo = 0;
    byte_t dev_q[$];
    byte_t host_q[$];
    serial_link_if link_if();
    serial_host_port_dev #(.BAUD_BPS(1000000)) serial_host_port_dev_inst (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(link_if),
        .tx_data_i(d_tx_data), .tx_valid_i(d_tx_valid), .tx_ready_o(d_tx_ready),
        .rx_data_o(d_rx_data), .rx_valid_o(d_rx_valid), .rx_ready_i(d_rx_ready));
    serial_host_port_host #(.BAUD_BPS(1000000)) serial_host_port_host_inst (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(link_if),
        .use_flow_i(use_flow), .cts_allow_i(cts_allow),
        .tx_data_i(h_tx_data), .tx_valid_i(h_tx_valid), .tx_ready_o(h_tx_ready),
        .rx_data_o(h_rx_data), .rx_valid_o(h_rx_valid));
    serial_host_port_checker #(.BIT_CYC(BIT)) checker_inst (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .dev_to_host_txd(link_if.dev_to_host_txd), .host_to_dev_rxd(link_if.host_to_dev_rxd),
        .dev_rts(link_if.dev_rts), .host_cts(link_if.host_cts),
        .pos_txd(link_if.pos_txd), .pos_rxd(link_if.pos_rxd));
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (rstn_i === 1'b1) begin
            if (h_rx_valid === 1'b1) host_q.push_back(h_rx_data);
            if (d_rx_valid === 1'b1 && d_rx_ready === 1'b1) dev_q.push_back(d_rx_data);
            if (link_if.dev_rts === 1'b0) rts_lo++;
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Holds valid until the edge that sees ready, then drops it half a cycle later.
    task automatic send(input bit at_dev, input byte_t b);
        int i;
        @(negedge clk_sys_i);
        if (at_dev) begin
            d_tx_data = b;
            d_tx_valid = 1'b1;
        end else begin
            h_tx_data = b;
            h_tx_valid = 1'b1;
        end
        for (i = 0; i < 2000; i++) begin
            @(posedge clk_sys_i);
            if ((at_dev ? d_tx_ready : h_tx_ready) === 1'b1) break;
        end
        @(negedge clk_sys_i);
        d_tx_valid = 1'b0;
        h_tx_valid = 1'b0;
    endtask
    task automatic take(input bit at_dev, input byte_t exp);
        byte_t got;
        int i;
        got = 'x;
        for (i = 0; i < 1000; i++) begin
            if (at_dev && dev_q.size() > 0) begin
                got = dev_q.pop_front();
                break;
            end
            if (!at_dev && host_q.size() > 0) begin
                got = host_q.pop_front();
                break;
            end
            @(negedge clk_sys_i);
        end
        chk(at_dev ? "dev_rx" : "host_rx", 32'(exp), 32'(got));
    endtask
    task automatic idle_for(input int n, input string what);
        int k;
        int bad;
        bad = 0;
        for (k = 0; k < n; k++) begin
            @(negedge clk_sys_i);
            if (link_if.dev_to_host_txd !== 1'b1 || d_tx_ready !== 1'b0) bad++;
        end
        chk(what, 0, bad);
    endtask
    task automatic t_frame();
        logic [9:0] word;
        int k;
        send(1'b1, 8'hA5);
        repeat (BIT / 2) @(negedge clk_sys_i);
        for (k = 0; k < 10; k++) begin
            word[k] = link_if.dev_to_host_txd;
            repeat (BIT) @(negedge clk_sys_i);
        end
        chk("dev_wire", 32'({1'b1, 8'hA5, 1'b0}), 32'(word));
        take(1'b0, 8'hA5);
        send(1'b1, 8'h01);
        send(1'b1, 8'h80);
        take(1'b0, 8'h01);
        take(1'b0, 8'h80);
        $display("t_frame done");
    endtask
    task automatic t_cts_block();
        cts_allow = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        d_tx_data = 8'h3C;
        d_tx_valid = 1'b1;
        idle_for(300, "held_idle");
        cts_allow = 1'b1;
        send(1'b1, 8'h3C);
        take(1'b0, 8'h3C);
        $display("t_cts_block done");
    endtask
    task automatic t_cts_mid();
        send(1'b1, 8'hC3);
        repeat (100) @(negedge clk_sys_i);
        cts_allow = 1'b0;
        d_tx_data = 8'h0F;
        d_tx_valid = 1'b1;
        take(1'b0, 8'hC3);
        idle_for(300, "after_drop");
        cts_allow = 1'b1;
        send(1'b1, 8'h0F);
        take(1'b0, 8'h0F);
        repeat (300) @(negedge clk_sys_i);
        chk("resent", 0, host_q.size());
        $display("t_cts_mid done");
    endtask
    task automatic t_rts();
        int base;
        base = rts_lo;
        send(1'b0, 8'h5A);
        send(1'b0, 8'hA6);
        take(1'b1, 8'h5A);
        take(1'b1, 8'hA6);
        repeat (10) @(negedge clk_sys_i);
        chk("rts_low", 2 * (`RTS_PULSE_CYC + 1), rts_lo - base);
        $display("t_rts done");
    endtask
    // Receiver stalls with both buffer entries full; nothing may be lost.
    task automatic t_buffer();
        d_rx_ready = 1'b0;
        send(1'b0, 8'h11);
        send(1'b0, 8'h22);
        repeat (300) @(negedge clk_sys_i);
        chk("rts_full", 0, 32'(link_if.dev_rts));
        chk("head", 8'h11, 32'(d_rx_data));
        d_rx_ready = 1'b1;
        take(1'b1, 8'h11);
        take(1'b1, 8'h22);
        repeat (5) @(negedge clk_sys_i);
        chk("rts_ready", 1, 32'(link_if.dev_rts));
        $display("t_buffer done");
    endtask
    task automatic t_no_flow();
        use_flow = 1'b0;
        cts_allow = 1'b0;
        send(1'b1, 8'hE7);
        take(1'b0, 8'hE7);
        use_flow = 1'b1;
        cts_allow = 1'b1;
        $display("t_no_flow done");
    endtask
    initial begin
        repeat (12) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        t_frame();
        t_cts_block();
        t_cts_mid();
        t_rts();
        t_buffer();
        t_no_flow();
        report_and_stop();
    end
    // The tests need about 3700 cycles; this leaves ample margin.
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        report_and_stop();
    end
endmodule
